// *** dual_bus_switch_core_buffering_tb_top.sv ***
// Testbench: traffic on both buses, peer path, credits and parity
`timescale 1ns/100ps
module dual_bus_switch_core_buffering_tb_top;
    logic clk;
    logic resetn;
    switch_core_pkg::beat_t inBeat [3];
    logic inValid [3];
    logic [3:0] inReady_ff [3];
    logic [3:0] linkWidth [3];
    switch_core_pkg::beat_t outBeat_ff [3];
    logic outValid_ff [3];
    logic ackValid [3];
    logic [10:0] ackBeats [3];
    logic [8:0] hdrCredit_ff [3];
    logic [8:0] dataCredit_ff [3];
    logic parityErr_ff;
    int err_count = 0;
    int checked = 0;
    int cyc = 0; // Edge index seen by the monitor
    int takeCyc; // Edge that took the last ingress beat
    logic [24:0] st0; // Arrival stamps of two packets
    logic [24:0] st1;
    switch_core_pkg::beat_t rxBeat [3][$];
    int rxCyc [3][$];

    switch_core u_switch_core (.clk(clk), .resetn(resetn),
        .inBeat(inBeat), .inValid(inValid), .inReady_ff(inReady_ff),
        .linkWidth(linkWidth), .outBeat_ff(outBeat_ff),
        .outValid_ff(outValid_ff), .ackValid(ackValid),
        .ackBeats(ackBeats), .hdrCredit_ff(hdrCredit_ff),
        .dataCredit_ff(dataCredit_ff), .parityErr_ff(parityErr_ff));
    egress_stack_model u_egress_stack_model (.clk(clk), .resetn(resetn),
        .outBeat_ff(outBeat_ff), .outValid_ff(outValid_ff),
        .ackValid(ackValid), .ackBeats(ackBeats));

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Collect every egress beat with the edge it came on
    always @(posedge clk) begin
        cyc <= cyc + 1;
        for (int p = 0; p < 3; p++) begin
            if (outValid_ff[p] === 1'b1) begin
                rxBeat[p].push_back(outBeat_ff[p]);
                rxCyc[p].push_back(cyc);
            end
        end
    end
    // Own even parity, upper dword in bit 1
    function automatic logic [1:0] evenPar(input logic [63:0] d);
        return {^d[63:32], ^d[31:0]};
    endfunction
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen,
                exp);
        end
    endtask
    // Offer one packet; entered at a rising edge, waits on ready per beat
    task automatic send(input int p, input int d, input int q, input int n,
        input logic [7:0] tag, input bit bad);
        switch_core_pkg::beat_t b;
        int w;
        for (int i = 0; i < n; i++) begin
            b = '0;
            b.data = {tag, 24'h000000, 32'(i)};
            b.par = evenPar(b.data) ^ {1'b0, bad};
            b.sop = (i == 0);
            b.eop = (i == n - 1);
            b.qsel = 2'(q);
            b.dest = 2'(d);
            inBeat[p] <= b;
            inValid[p] <= 1'b1;
            w = 0;
            @(negedge clk);
            while (inReady_ff[p][q] !== 1'b1 && w < 200) begin
                w++;
                @(negedge clk);
            end
            chk(w < 200, 1'b1);
            takeCyc = cyc;
            @(posedge clk);
        end
        inValid[p] <= 1'b0;
    endtask
    // Await a packet at egress port p and judge every beat
    task automatic expectPkt(input int p, input int n, input logic [7:0] tag,
        input bit sf, output logic [24:0] st);
        switch_core_pkg::beat_t b;
        int c;
        int c0;
        int w;
        w = 0;
        c0 = 0;
        st = '0;
        while (rxBeat[p].size() < n && w < 400) begin
            w++;
            @(negedge clk);
        end
        chk(rxBeat[p].size() >= n, 1'b1);
        for (int i = 0; i < n && rxBeat[p].size() > 0; i++) begin
            b = rxBeat[p].pop_front();
            c = rxCyc[p].pop_front();
            if (i == 0) begin
                c0 = c;
                st = b.stamp;
            end
            chk(b.data, {tag, 24'h000000, 32'(i)});
            chk(b.par, evenPar(b.data));
            chk({b.sop, b.eop}, {i == 0, i == n - 1});
            chk(c - c0, i);
        end
        if (sf)
            chk(c0 > takeCyc, 1'b1);
    endtask
    // Reset view: nothing ready, credits already shown
    task automatic t_reset;
        for (int p = 0; p < 3; p++)
            chk(inReady_ff[p], 4'h0);
        chk({hdrCredit_ff[0], hdrCredit_ff[1], hdrCredit_ff[2]},
            {9'h040, 9'h040, 9'h040});
        chk({dataCredit_ff[0], dataCredit_ff[1], dataCredit_ff[2]},
            {9'h1a0, 9'h040, 9'h1a0});
        $display("test reset done");
    endtask
    // Down bus: every queue kind, insertion within its 6 beats
    task automatic t_down;
        for (int q = 0; q < 4; q++) begin
            @(posedge clk);
            send(0, 1 + q % 2, q, (q == 3) ? 2 : 4, 8'(8'h10 + q), 1'b0);
            expectPkt(1 + q % 2, (q == 3) ? 2 : 4, 8'(8'h10 + q), 1'b0,
                st1);
            if (q == 0)
                st0 = st1;
        end
        chk(st1 > st0, 1'b1);
        $display("test down done");
    endtask
    // Both buses at once, then peer transfers through the decoupler
    task automatic t_buses;
        @(posedge clk);
        fork
            send(0, 2, 0, 4, 8'h21, 1'b0);
            send(1, 0, 2, 4, 8'h22, 1'b0);
        join
        expectPkt(2, 4, 8'h21, 1'b0, st0);
        expectPkt(0, 4, 8'h22, 1'b0, st0);
        @(posedge clk);
        send(1, 2, 0, 8, 8'h31, 1'b0);
        expectPkt(2, 8, 8'h31, 1'b0, st0);
        @(posedge clk);
        send(2, 1, 2, 3, 8'h32, 1'b0);
        expectPkt(1, 3, 8'h32, 1'b0, st0);
        $display("test buses done");
    endtask
    // Narrow ingress stores whole packet first
    task automatic t_store;
        @(posedge clk);
        linkWidth[1] <= 4'h1;
        send(1, 0, 0, 6, 8'h41, 1'b0);
        expectPkt(0, 6, 8'h41, 1'b1, st0);
        @(posedge clk);
        linkWidth[1] <= 4'h8;
        $display("test store done");
    endtask
    // Bad ingress parity is flagged and regenerated
    task automatic t_parity;
        chk(parityErr_ff, 1'b0);
        @(posedge clk);
        send(0, 1, 0, 2, 8'h51, 1'b1);
        expectPkt(1, 2, 8'h51, 1'b0, st0);
        chk(parityErr_ff, 1'b1);
        $display("test parity done");
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        resetn = 1'b0;
        for (int p = 0; p < 3; p++) begin
            inBeat[p] = '0;
            inValid[p] = 1'b0;
            linkWidth[p] = 4'h8;
        end
        repeat (2) @(posedge clk);
        #1;
        t_reset();
        @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        t_down();
        t_buses();
        t_store();
        t_parity();
        give_verdict();
    end
    // Watchdog well beyond the 90 or so cycles the tests need
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
endmodule

// *** egress_stack_model.sv ***
// Egress stack model: counts delivered beats and acknowledges packets
`timescale 1ns/100ps
module egress_stack_model #(
    parameter int ACK_WAIT = 6
) (
    input wire logic clk,
    input wire logic resetn,
    input wire switch_core_pkg::beat_t outBeat_ff [3],
    input wire logic outValid_ff [3],
    output logic ackValid [3],
    output logic [10:0] ackBeats [3]
);
    int beats [3]; // Beats of the packet in flight
    int wt [3]; // Cycles before the next ack may go
    int pend [3][$]; // Delivered packets awaiting ack
    // Ack each packet late; a released count shows its inverse, not stale
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < 3; p++) begin
                ackValid[p] <= 1'b0;
                ackBeats[p] <= 11'h000;
                beats[p] = 0;
                wt[p] = ACK_WAIT;
                pend[p].delete();
            end
        end else begin
            for (int p = 0; p < 3; p++) begin
                ackValid[p] <= 1'b0;
                ackBeats[p] <= ~ackBeats[p];
                if (outValid_ff[p] === 1'b1) begin
                    beats[p]++;
                    if (outBeat_ff[p].eop) begin
                        pend[p].push_back(beats[p]);
                        beats[p] = 0;
                    end
                end
                if (wt[p] > 0)
                    wt[p]--;
                else if (pend[p].size() > 0) begin
                    ackValid[p] <= 1'b1;
                    ackBeats[p] <= 11'(pend[p].pop_front());
                    wt[p] = ACK_WAIT;
                end
            end
        end
    end
endmodule

// *** stage_fifo.sv ***
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module stage_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH]; // Storage, no reset needed
    logic [AW-1:0] wrPtr_ff; // Next slot to fill
    logic [AW-1:0] rdPtr_ff; // Oldest entry
    logic [CW-1:0] count_ff; // Entries held
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign inReady = (count_ff != FULL);
    assign outValid = (count_ff != '0);
    assign outData = mem_ff[rdPtr_ff];
    assign count = count_ff;

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    // Pointers wrap explicitly since depth need not be a power of two
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) wrPtr_ff <= (wrPtr_ff == LAST) ? '0 : wrPtr_ff + 1'b1;
            if (pop) rdPtr_ff <= (rdPtr_ff == LAST) ? '0 : rdPtr_ff + 1'b1;
            count_ff <= count_ff + CW'(push) - CW'(pop);
        end
    end
endmodule

// *** switch_core.sv ***
// Switch core: ingress queue sets, dual buses, decoupler, egress accounting
`timescale 1ns/100ps
// Overview of operation
// - Three ports: index 0 upstream, 1,2 downstream
// - Down traffic on down bus, up on up
// - Peer packets: up bus, decoupler, down bus
// - Four ingress queues per port incl. insertion
// - Queue full on bytes or packet count
// - Posted, completion: 8 KB/64, credits 64/416
// - Non-posted: 1.5 KB/64, credits 64/64
// - Shared output/replay buffer freed by acks
// - Output buffer: 8 KB or 32 packets
// - Output buffer lets core send at x8
// - Decoupler holds one 2112-byte packet
// - Insertion buffer: 12 dwords, two packets
// - 66-bit beats, even parity per dword
// - Port presents data to core each cycle
// - Queued packets move at x8 over buses
// - Egress beats written gap-free to buffer
// - Each stack is one x8 stack
// - Narrower ingress stores, else cut-through
// - 25-bit timer stamps each arriving packet
module switch_core (
    input wire logic clk,
    input wire logic resetn,
    input wire switch_core_pkg::beat_t inBeat [switch_core_pkg::NPORT],
    input wire logic inValid [switch_core_pkg::NPORT],
    output logic [3:0] inReady_ff [switch_core_pkg::NPORT],
    input wire logic [3:0] linkWidth [switch_core_pkg::NPORT],
    output switch_core_pkg::beat_t outBeat_ff [switch_core_pkg::NPORT],
    output logic outValid_ff [switch_core_pkg::NPORT],
    input wire logic ackValid [switch_core_pkg::NPORT],
    input wire logic [10:0] ackBeats [switch_core_pkg::NPORT],
    output logic [8:0] hdrCredit_ff [3],
    output logic [8:0] dataCredit_ff [3],
    output logic parityErr_ff
);
    localparam int NP = switch_core_pkg::NPORT;
    localparam int SD = switch_core_pkg::STAGE_DEPTH;
    localparam logic [4:0] SFULL = 5'(SD);
    localparam logic [1:0] UPI = switch_core_pkg::UP_IDX;

    // Ingress staging FIFO ports
    switch_core_pkg::beat_t head [NP]; // Head beat of each port
    logic headValid [NP];
    logic pop [NP]; // Head taken by a bus
    logic push [NP]; // Beat accepted from the stack
    logic [4:0] stCount [NP];
    logic [4:0] eopCnt_ff [NP]; // Whole packets staged
    logic midPkt_ff [NP]; // Inside a packet on ingress
    logic [10:0] qBeats_ff [NP][4]; // Data queue use
    logic [6:0] qPkts_ff [NP][4]; // Descriptor queue use
    logic [10:0] outBeats_ff [NP]; // Output/replay use
    logic [6:0] outPkts_ff [NP];
    logic outRoom [NP]; // Room for one largest packet
    logic [24:0] timer_ff; // Free-running arrival clock
    logic parBad [NP]; // Popped beat fails parity
    logic egValid [NP]; // Bus beat heading to egress
    switch_core_pkg::beat_t egBeat [NP];

    // Free-running stamp source, advancing each core cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) timer_ff <= '0;
        else timer_ff <= timer_ff + 25'h0000001;
    end

    // Per port ingress queue set and egress accounting
    for (genvar p = 0; p < NP; p++) begin : g_port
        switch_core_pkg::beat_t stamped;
        logic [4:0] nxt_stCount;
        logic nxt_midPkt;
        // Stamp the descriptor word as the packet arrives
        always_comb begin
            stamped = inBeat[p];
            stamped.stamp = timer_ff;
        end
        assign push[p] = inValid[p] && inReady_ff[p][inBeat[p].qsel];
        assign nxt_stCount = stCount[p] + 5'(push[p]) - 5'(pop[p]);
        assign nxt_midPkt = push[p] ? (inBeat[p].sop || midPkt_ff[p]) &&
                            !inBeat[p].eop : midPkt_ff[p];
        // Room for a largest packet keeps egress bursts gap-free at x8
        assign outRoom[p] = (switch_core_pkg::OUT_BEAT_CAP - outBeats_ff[p] >=
            switch_core_pkg::MAXPKT_BEATS) &&
            (outPkts_ff[p] < switch_core_pkg::OUT_PKT_CAP);
        assign parBad[p] = pop[p] &&
            (switch_core_pkg::dwPar(head[p].data) != head[p].par);

        stage_fifo #(.WIDTH(switch_core_pkg::BEAT_W), .DEPTH(SD)) u_stage (
            .clk(clk), .resetn(resetn), .inValid(push[p]), .inReady(),
            .inData(stamped), .outValid(headValid[p]), .outReady(pop[p]),
            .outData(head[p]), .count(stCount[p])
        );

        // Staged packet count and ingress framing
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                eopCnt_ff[p] <= '0;
                midPkt_ff[p] <= 1'b0;
            end else begin
                eopCnt_ff[p] <= eopCnt_ff[p] + 5'(push[p] && inBeat[p].eop)
                                - 5'(pop[p] && head[p].eop);
                midPkt_ff[p] <= nxt_midPkt;
            end
        end

        for (genvar q = 0; q < 4; q++) begin : g_queue
            localparam logic [10:0] BCAP =
                11'(switch_core_pkg::Q_BYTES[q] / switch_core_pkg::BEAT_BYTES);
            logic [10:0] nxt_beats;
            logic [6:0] nxt_pkts;
            // Packet counted at its first beat, freed at its last
            assign nxt_beats = qBeats_ff[p][q]
                + 11'(push[p] && inBeat[p].qsel == 2'(q))
                - 11'(pop[p] && head[p].qsel == 2'(q));
            assign nxt_pkts = qPkts_ff[p][q]
                + 7'(push[p] && inBeat[p].sop && inBeat[p].qsel == 2'(q))
                - 7'(pop[p] && head[p].eop && head[p].qsel == 2'(q));
            // Ready from next counts so a granted beat always fits
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    qBeats_ff[p][q] <= '0;
                    qPkts_ff[p][q] <= '0;
                    inReady_ff[p][q] <= 1'b0;
                end else begin
                    qBeats_ff[p][q] <= nxt_beats;
                    qPkts_ff[p][q] <= nxt_pkts;
                    inReady_ff[p][q] <= (nxt_beats < BCAP) &&
                        (nxt_midPkt ||
                         nxt_pkts < switch_core_pkg::QPKT_CAP[q]) &&
                        (nxt_stCount < SFULL);
                end
            end
        end

        // Output/replay occupancy: grows per egress beat, shrinks per ack
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                outBeats_ff[p] <= '0;
                outPkts_ff[p] <= '0;
                outValid_ff[p] <= 1'b0;
                outBeat_ff[p] <= '0;
            end else begin
                outBeats_ff[p] <= outBeats_ff[p] + 11'(egValid[p])
                    - (ackValid[p] ? ackBeats[p] : 11'h000);
                outPkts_ff[p] <= outPkts_ff[p]
                    + 7'(egValid[p] && egBeat[p].sop)
                    - 7'(ackValid[p]);
                outValid_ff[p] <= egValid[p];
                outBeat_ff[p] <= egBeat[p];
                outBeat_ff[p].par <= switch_core_pkg::dwPar(egBeat[p].data);
            end
        end
    end

    // Decoupler between the buses
    switch_core_pkg::beat_t decHead;
    logic decValid, decPush, decPop;
    logic [8:0] decCount;
    int upSrc; // Up bus source index, 1 or 2
    stage_fifo #(.WIDTH(switch_core_pkg::BEAT_W),
                 .DEPTH(switch_core_pkg::DEC_BEATS)) u_decoupler (
        .clk(clk),
        .resetn(resetn),
        .inValid(decPush),
        .inReady(),
        .inData(head[upSrc]),
        .outValid(decValid),
        .outReady(decPop),
        .outData(decHead),
        .count(decCount)
    );

    // Eligibility: store-and-forward when ingress is narrower than egress
    function automatic logic mayStart(input int s, input logic [1:0] d);
        return (linkWidth[s] >= linkWidth[d]) || (eopCnt_ff[s] != 5'h00) ||
               (stCount[s] == SFULL);
    endfunction

    // Up bus: ports 1 and 2 toward port 0 or the decoupler
    switch_core_pkg::bus_state_t upState_ff;
    logic upLast_ff; // Last served: 0 means index 1
    logic upSel_ff; // Active source: 0 means index 1
    logic upToDec_ff; // Active packet is peer traffic
    logic upElig [2];
    logic upPick; // Chosen source in idle
    logic upMove; // A beat crosses the up bus
    for (genvar i = 0; i < 2; i++) begin : g_upelig
        wire logic [1:0] d = head[i+1].dest;
        wire logic peer = (d != UPI) && (d != 2'(i + 1)) && (d != 2'h3);
        assign upElig[i] = headValid[i+1] && head[i+1].sop &&
            ((d == UPI) ? outRoom[0] && mayStart(i + 1, d)
                        : peer && decCount == 9'h000 &&
                          mayStart(i + 1, d));
    end
    assign upPick = upElig[1] && (!upElig[0] || !upLast_ff);
    assign upSrc = upSel_ff ? 2 : 1;
    assign upMove = (upState_ff == switch_core_pkg::BUS_XFER) &&
                    headValid[upSrc];
    assign decPush = upMove && upToDec_ff;
    assign egValid[0] = upMove && !upToDec_ff;
    assign egBeat[0] = head[upSrc];

    // Up bus sequencing, one packet at a time
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            upState_ff <= switch_core_pkg::BUS_IDLE;
            upLast_ff <= 1'b0;
            upSel_ff <= 1'b0;
            upToDec_ff <= 1'b0;
        end else begin
            unique case (upState_ff)
                switch_core_pkg::BUS_IDLE: begin
                    if (upElig[0] || upElig[1]) begin
                        upSel_ff <= upPick;
                        upLast_ff <= upPick;
                        upToDec_ff <= head[upPick ? 2 : 1].dest != UPI;
                        upState_ff <= switch_core_pkg::BUS_XFER;
                    end
                end
                switch_core_pkg::BUS_XFER: begin
                    if (upMove && head[upSrc].eop)
                        upState_ff <= switch_core_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Down bus: port 0 or the decoupler toward ports 1 and 2
    switch_core_pkg::bus_state_t dnState_ff;
    logic dnLast_ff; // Last served was the decoupler
    logic dnFromDec_ff; // Active source is the decoupler
    logic [1:0] dnDest_ff; // Active egress index
    logic dnElig0, dnEligD, dnPickD, dnMove; // Offers, pick, beat moves
    switch_core_pkg::beat_t dnBeat;
    assign dnElig0 = headValid[0] && head[0].sop && head[0].dest != UPI &&
        head[0].dest != 2'h3 && outRoom[head[0].dest] &&
        mayStart(0, head[0].dest);
    assign dnEligD = decValid && decHead.sop && outRoom[decHead.dest];
    assign dnPickD = dnEligD && (!dnElig0 || !dnLast_ff);
    assign dnBeat = dnFromDec_ff ? decHead : head[0];
    assign dnMove = (dnState_ff == switch_core_pkg::BUS_XFER) &&
                    (dnFromDec_ff ? decValid : headValid[0]);
    assign decPop = dnMove && dnFromDec_ff;
    assign pop[0] = dnMove && !dnFromDec_ff;
    assign pop[1] = upMove && !upSel_ff;
    assign pop[2] = upMove && upSel_ff;
    for (genvar e = 1; e < NP; e++) begin : g_dneg
        assign egValid[e] = dnMove && dnDest_ff == 2'(e);
        assign egBeat[e] = dnBeat;
    end

    // Down bus sequencing runs alongside the up bus
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dnState_ff <= switch_core_pkg::BUS_IDLE;
            dnLast_ff <= 1'b0;
            dnFromDec_ff <= 1'b0;
            dnDest_ff <= 2'h1;
        end else begin
            unique case (dnState_ff)
                switch_core_pkg::BUS_IDLE: begin
                    if (dnElig0 || dnEligD) begin
                        dnFromDec_ff <= dnPickD;
                        dnLast_ff <= dnPickD;
                        dnDest_ff <= dnPickD ? decHead.dest : head[0].dest;
                        dnState_ff <= switch_core_pkg::BUS_XFER;
                    end
                end
                switch_core_pkg::BUS_XFER: begin
                    if (dnMove && dnBeat.eop)
                        dnState_ff <= switch_core_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Credits are fixed; parity failures stay flagged until reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hdrCredit_ff <= switch_core_pkg::HDR_CREDIT;
            dataCredit_ff <= switch_core_pkg::DATA_CREDIT;
            parityErr_ff <= 1'b0;
        end else begin
            parityErr_ff <= parityErr_ff || parBad[0] || parBad[1] ||
                            parBad[2];
        end
    end

    // Checks share the core clock and rest while reset is low
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_upOnly;
        outValid_ff[0] |-> $past(upMove) && !$past(upToDec_ff);
    endproperty
    a_upOnly: assert property (p_upOnly) else $error("bad up source");
    property p_peerDec;
        decPush && head[upSrc].sop |-> head[upSrc].dest != UPI && upSrc != 0;
    endproperty
    a_peerDec: assert property (p_peerDec) else $error("bad peer push");
    property p_postCap;
        qPkts_ff[1][0] <= 7'h40 && qBeats_ff[1][0] <= 11'h400;
    endproperty
    a_postCap: assert property (p_postCap) else $error("posted full");
    property p_npCap;
        qBeats_ff[0][1] <= 11'h0c0;
    endproperty
    a_npCap: assert property (p_npCap) else $error("np overflow");
    property p_insCap;
        qPkts_ff[2][3] <= 7'h02 && qBeats_ff[2][3] <= 11'h006;
    endproperty
    a_insCap: assert property (p_insCap) else $error("insert full");
    property p_outCap;
        outPkts_ff[1] <= 7'h20 && outBeats_ff[1] <= 11'h400;
    endproperty
    a_outCap: assert property (p_outCap) else $error("output full");
    property p_egPar;
        outValid_ff[2] |-> outBeat_ff[2].par ==
            {^outBeat_ff[2].data[63:32], ^outBeat_ff[2].data[31:0]};
    endproperty
    a_egPar: assert property (p_egPar) else $error("egress parity");
    property p_timer;
        $past(resetn) |-> timer_ff == $past(timer_ff) + 25'h0000001;
    endproperty
    a_timer: assert property (p_timer) else $error("timer stalled");
    property p_parErr;
        (parBad[0] || parBad[1] || parBad[2]) |=> parityErr_ff [*3];
    endproperty
    a_parErr: assert property (p_parErr) else $error("parity flag");
    property p_decOne;
        $rose(upToDec_ff) |-> decCount == 9'h000;
    endproperty
    a_decOne: assert property (p_decOne) else $error("decoupler busy");
    c_peer: cover property (@(posedge clk) decPop ##1 outValid_ff[1]);
    c_both: cover property (@(posedge clk) upMove && dnMove);
    c_store: cover property (@(posedge clk)
        $rose(dnMove) && linkWidth[0] < linkWidth[dnDest_ff]);
    c_perr: cover property (@(posedge clk) $rose(parityErr_ff));
endmodule

// *** switch_core_pkg.sv ***
// Shared constants, beat format and bus states of the switch core
package switch_core_pkg;
    // Port indexes: 0 is switch port 0 (upstream), 1 and 2 are ports 2 and 4
    localparam int NPORT = 32'h3;
    localparam logic [1:0] UP_IDX = 2'h0;
    localparam int NQUEUE = 32'h4;
    // Ingress queue selectors
    localparam logic [1:0] Q_POST = 2'h0;
    localparam logic [1:0] Q_NONPOST = 2'h1;
    localparam logic [1:0] Q_CPL = 2'h2;
    localparam logic [1:0] Q_INSERT = 2'h3;
    // One beat moves two dwords
    localparam int BEAT_BYTES = 32'h8;
    // Byte and packet capacity per queue: posted, non-posted, completion, insert
    localparam int Q_BYTES [NQUEUE] = '{32'h2000, 32'h600, 32'h2000, 32'h30};
    localparam logic [6:0] QPKT_CAP [NQUEUE] = '{7'h40, 7'h40, 7'h40, 7'h02};
    // Advertised credits for posted, non-posted, completion
    localparam logic [8:0] HDR_CREDIT [3] = '{9'h040, 9'h040, 9'h040};
    localparam logic [8:0] DATA_CREDIT [3] = '{9'h1a0, 9'h040, 9'h1a0};
    // Output and replay buffer limits
    localparam int OUT_BYTES = 32'h2000;
    localparam logic [6:0] OUT_PKT_CAP = 7'h20;
    // Decoupler holds one largest packet
    localparam int DEC_BYTES = 32'h840;
    localparam int DEC_BEATS = DEC_BYTES / BEAT_BYTES;
    localparam logic [10:0] MAXPKT_BEATS = 11'(DEC_BEATS);
    localparam logic [10:0] OUT_BEAT_CAP = 11'(OUT_BYTES / BEAT_BYTES);
    // Ingress staging depth and time-stamp width
    localparam int STAGE_DEPTH = 32'h10;
    localparam int STAMP_W = 32'h19;

    // One 66-bit datapath beat plus its routing side-band
    typedef struct packed {
        logic [63:0] data;
        logic [1:0] par;
        logic sop;
        logic eop;
        logic [1:0] qsel;
        logic [1:0] dest;
        logic [STAMP_W-1:0] stamp;
    } beat_t;

    localparam int BEAT_W = $bits(beat_t);

    // Bus transfer state
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_XFER = 2'b10
    } bus_state_t;

    // Even parity per dword, upper dword in bit 1
    function automatic logic [1:0] dwPar(input logic [63:0] d);
        return {^d[63:32], ^d[31:0]};
    endfunction
endpackage
